// *** logic/emipi_pkg.sv ***
package emipi_pkg;

   // Register addresses on the special function register port
   localparam logic [7:0]  PAGE_SEL_ADDR  = 8'hAA;  // Page select register
   localparam logic [7:0]  CFG_ADDR       = 8'hB2;  // Interface configuration register
   // Values after reset
   localparam logic [7:0]  PAGE_SEL_RESET = 8'h00;
   localparam logic [7:0]  CFG_RESET      = 8'h03;
   localparam logic [7:0]  CFG_RD_MASK    = 8'h1F;  // Bits 7:5 read as zero
   // Configuration field positions
   localparam int          MUX_SEL_POS    = 4;      // mux_select_bit
   localparam int          MODE_LSB       = 2;      // routing_mode_field [3:2]
   // Routing mode codes
   localparam logic [1:0]  MODE_ONCHIP    = 2'h0;
   localparam logic [1:0]  MODE_SPLIT_LAT = 2'h1;
   localparam logic [1:0]  MODE_SPLIT_PG  = 2'h2;
   localparam logic [1:0]  MODE_OFFCHIP   = 2'h3;
   // Split boundary at 8 kB
   localparam logic [15:0] SPLIT_BOUNDARY = 16'h2000;
   // Package variants
   localparam logic [1:0]  VAR_LARGE      = 2'h0;
   localparam logic [1:0]  VAR_MID        = 2'h1;
   localparam logic [1:0]  VAR_SMALL      = 2'h2;
   // Strobe phase length in cycles, long enough to cover the input synchroniser
   localparam logic [2:0]  STROBE_CYC     = 3'h6;
   // Pin values after reset
   localparam logic [31:0] PIN_RESET      = 32'h0000_0000;

   // One bit per pin of ports 1 to 4
   typedef struct packed {
      logic [7:0] p4;
      logic [7:0] p3;
      logic [7:0] p2;
      logic [7:0] p1;
   } emipi_ports_t;

   // Request from the CPU core for one external move
   typedef struct packed {
      logic        wr;      // 1 = write, 0 = read
      logic        is8;     // 8-bit address operand form
      logic [15:0] addr16;  // Full address for the 16-bit form
      logic [7:0]  low;     // Low byte for the 8-bit form
      logic [7:0]  wdata;   // Write data
   } emipi_req_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_HOLD,
      ST_STROBE,
      ST_DONE
   } emipi_state_t;

endpackage : emipi_pkg

// *** logic/emipi_pin_drive.sv ***
`timescale 1ns/1ps
// Registered pin multiplexer between the interface and the port latches
module emipi_pin_drive
   import emipi_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire emipi_ports_t own_i,        // Pins claimed by the interface
   input  wire emipi_ports_t external_mem_if_out_i,   // Interface pin levels
   input  wire emipi_ports_t external_mem_if_oe_i,    // Interface driver enables
   input  wire emipi_ports_t latch_i,      // Port latch values
   input  wire emipi_ports_t xbar_oe_i,    // Normal port/crossbar enables
   output emipi_ports_t      pin_out_o,
   output emipi_ports_t      pin_oe_o
);

   //////////////////////////////////////////////////////////////////////////
   // Claimed pins follow the interface, all others the latches and crossbar
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_out_o <= PIN_RESET;
         pin_oe_o  <= PIN_RESET;
      end else begin
         pin_out_o <= (own_i & external_mem_if_out_i) | (~own_i & latch_i);
         pin_oe_o  <= (own_i & external_mem_if_oe_i) | (~own_i & xbar_oe_i);
      end
   end

endmodule : emipi_pin_drive

// *** logic/emipi_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Claim pins only during off-chip external moves
// - Afterwards pins revert to latches or crossbar
// - Disable drivers of input pins during access
// - Never change pin drive type
// - Large variant pin mapping per mode
// - Mid multiplexed only; small no off-chip
// - 8-bit moves take high byte from page, or from the address-high latches in split-latch mode
// - Page N maps N*0x100 onward; resets zero
// - Mux bit: 0 multiplexed, 1 separate pins
// - Mode field routes on-chip, split or off-chip
module emipi_top
   import emipi_pkg::*;
#(
   parameter logic [1:0] VARIANT = VAR_LARGE   // Package variant
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   // Special function register port
   input  wire logic [7:0]   sfr_addr_i,
   input  wire logic         sfr_wr_i,
   input  wire logic [7:0]   sfr_wdata_i,
   output logic [7:0]        sfr_rdata_o,
   // External move requests from the core
   input  wire logic         xm_req_i,
   input  wire emipi_req_t   xm_i,
   output logic              xm_done_o,
   output logic              xm_offchip_o,
   output logic [7:0]        xm_rdata_o,
   // Port pins
   input  wire emipi_ports_t latch_i,
   input  wire emipi_ports_t xbar_oe_i,
   input  wire emipi_ports_t pin_in_i,
   output emipi_ports_t      pin_out_o,
   output emipi_ports_t      pin_oe_o
);

   //////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]   page_q;       // external_data_space_ram_page_select
   logic [7:0]   cfg_q;        // Configuration register
   emipi_state_t state_q;      // Access sequencer
   logic [2:0]   cnt_q;        // Strobe phase counter
   logic [15:0]  addr_q;       // Effective address of the access
   logic         wr_q;         // Access is a write
   logic [7:0]   wdata_q;      // Write data
   logic [7:0]   sync1_q, sync2_q, sync3_q; // Data input synchroniser stages
   logic [7:0]   rd_filt_q;    // Accepted data input level
   logic         mux_eff;      // Multiplexed pinout in force
   logic [1:0]   mode;         // routing_mode_field
   logic [7:0]   hi_byte;      // High byte for 8-bit moves
   logic [15:0]  eff_addr;     // Address of a new request
   logic         go_off;       // New request goes off-chip
   emipi_ports_t own;          // Claimed pins
   emipi_ports_t external_mem_if_out;     // Interface pin levels
   emipi_ports_t external_mem_if_oe;      // Interface driver enables
   logic [7:0]   data_in;      // Data lines from the active port

   //////////////////////////////////////////////////////////////////////////
   // Configuration decode
   always_comb begin
      mode    = cfg_q[MODE_LSB +: 2];
      // Only the large variant may leave the multiplexed pinout
      mux_eff = (VARIANT != VAR_LARGE) || !cfg_q[MUX_SEL_POS];
      // Split without bank select takes the high byte from the address-high latches
      if (mode == MODE_SPLIT_LAT) begin
         hi_byte = (VARIANT == VAR_LARGE && mux_eff) ? latch_i.p3 : latch_i.p2;
      end else begin
         hi_byte = page_q;
      end
      eff_addr = xm_i.is8 ? {hi_byte, xm_i.low} : xm_i.addr16;
      // Route the request
      if (VARIANT == VAR_SMALL || mode == MODE_ONCHIP) begin
         go_off = 1'b0;
      end else if (mode == MODE_OFFCHIP) begin
         go_off = 1'b1;
      end else begin
         go_off = (eff_addr >= SPLIT_BOUNDARY);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         page_q <= PAGE_SEL_RESET;
         cfg_q  <= CFG_RESET;
      end else if (sfr_wr_i) begin
         if (sfr_addr_i == PAGE_SEL_ADDR) begin
            page_q <= sfr_wdata_i;
         end else if (sfr_addr_i == CFG_ADDR) begin
            cfg_q  <= sfr_wdata_i & CFG_RD_MASK;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register reads, one cycle after the address
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_addr_i == PAGE_SEL_ADDR) begin
         sfr_rdata_o <= page_q;
      end else if (sfr_addr_i == CFG_ADDR) begin
         sfr_rdata_o <= cfg_q;
      end else begin
         sfr_rdata_o <= 8'h00;   // Unmapped address
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Access sequencer
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q   <= 3'h0;
         addr_q  <= 16'h0000;
         wr_q    <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (xm_req_i) begin
                  addr_q  <= eff_addr;
                  wr_q    <= xm_i.wr;
                  wdata_q <= xm_i.wdata;
                  cnt_q   <= 3'h0;
                  // On-chip accesses never claim pins
                  state_q <= go_off ? ST_ADDR : ST_DONE;
               end
            end
            ST_ADDR: begin
               // Multiplexed: hold address after the latch pulse
               state_q <= mux_eff ? ST_HOLD : ST_STROBE;
            end
            ST_HOLD: begin
               state_q <= ST_STROBE;
            end
            ST_STROBE: begin
               if (cnt_q == STROBE_CYC - 3'h1) begin
                  state_q <= ST_DONE;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Completion and read data to the core
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         xm_done_o    <= 1'b0;
         xm_offchip_o <= 1'b0;
         xm_rdata_o   <= 8'h00;
      end else begin
         xm_done_o <= (state_q == ST_DONE);
         if (state_q == ST_IDLE && xm_req_i) begin
            xm_offchip_o <= go_off;
         end
         // Sample read data at the end of the strobe phase
         if (state_q == ST_STROBE && cnt_q == STROBE_CYC - 3'h1 && !wr_q) begin
            xm_rdata_o <= rd_filt_q;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Data input synchroniser; change accepted when stages two and three agree
   assign data_in = (VARIANT == VAR_LARGE) ? pin_in_i.p4 : pin_in_i.p3;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync1_q   <= 8'h00;
         sync2_q   <= 8'h00;
         sync3_q   <= 8'h00;
         rd_filt_q <= 8'h00;
      end else begin
         sync1_q <= data_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            rd_filt_q <= sync3_q;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interface pin levels; drive type stays with the port configuration
   always_comb begin
      own      = '0;
      external_mem_if_out = '0;
      external_mem_if_oe  = '0;
      if (state_q != ST_IDLE && state_q != ST_DONE) begin
         // Strobes on port 1, active low, driven outputs only
         own.p1[7:6]     = 2'h3;
         external_mem_if_oe.p1[7:6] = 2'h3;
         external_mem_if_out.p1[7] = !(state_q == ST_STROBE && wr_q);
         external_mem_if_out.p1[6] = !(state_q == ST_STROBE && !wr_q);
         if (mux_eff) begin
            own.p1[5]      = 1'b1;
            external_mem_if_oe.p1[5]  = 1'b1;
            external_mem_if_out.p1[5] = (state_q == ST_ADDR);
            if (VARIANT == VAR_LARGE) begin
               // Shared lines on port 4, high address on port 3
               own.p4 = 8'hFF;
               own.p3 = 8'hFF;
               external_mem_if_oe.p3  = 8'hFF;
               external_mem_if_out.p3 = addr_q[15:8];
               external_mem_if_out.p4 = (state_q == ST_STROBE) ? wdata_q : addr_q[7:0];
               external_mem_if_oe.p4  = (state_q == ST_STROBE && !wr_q) ? 8'h00 : 8'hFF;
            end else begin
               // Shared lines on port 3, high address on port 2
               own.p3 = 8'hFF;
               own.p2 = 8'hFF;
               external_mem_if_oe.p2  = 8'hFF;
               external_mem_if_out.p2 = addr_q[15:8];
               external_mem_if_out.p3 = (state_q == ST_STROBE) ? wdata_q : addr_q[7:0];
               external_mem_if_oe.p3  = (state_q == ST_STROBE && !wr_q) ? 8'h00 : 8'hFF;
            end
         end else begin
            // Data on port 4, low address port 3, high port 2
            own.p4 = 8'hFF;
            own.p3 = 8'hFF;
            own.p2 = 8'hFF;
            external_mem_if_oe.p3  = 8'hFF;
            external_mem_if_oe.p2  = 8'hFF;
            external_mem_if_out.p3 = addr_q[7:0];
            external_mem_if_out.p2 = addr_q[15:8];
            external_mem_if_out.p4 = wdata_q;
            external_mem_if_oe.p4  = wr_q ? 8'hFF : 8'h00;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin output registers
   emipi_pin_drive u_pin_drive (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .own_i      (own),
      .external_mem_if_out_i (external_mem_if_out),
      .external_mem_if_oe_i  (external_mem_if_oe),
      .latch_i    (latch_i),
      .xbar_oe_i  (xbar_oe_i),
      .pin_out_o  (pin_out_o),
      .pin_oe_o   (pin_oe_o)
   );

   //////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   idle_pins_free_a: assert property (
      (state_q == ST_IDLE) |=> (pin_oe_o == $past(xbar_oe_i)) && (pin_out_o == $past(latch_i)))
      else $error("Pins not returned to port control while idle");
   read_drv_off_a: assert property (
      (state_q == ST_STROBE && !wr_q && VARIANT == VAR_LARGE) |=> (pin_oe_o.p4 == 8'h00))
      else $error("Data drivers on during read");
   page_reset_a: assert property (
      $fell(rst_i) |-> (page_q == PAGE_SEL_RESET))
      else $error("Page register not zero after reset");
   page_high_a: assert property (
      (state_q == ST_IDLE && xm_req_i && xm_i.is8 && mode == MODE_SPLIT_PG)
      |=> (addr_q == {$past(page_q), $past(xm_i.low)}))
      else $error("8-bit move high byte not from page register");
   onchip_only_a: assert property (
      (state_q == ST_IDLE && xm_req_i && mode == MODE_ONCHIP)
      |=> (state_q == ST_DONE) ##1 (xm_done_o && !xm_offchip_o))
      else $error("On-chip mode claimed the pins");
   strobe_len_a: assert property (
      $rose(state_q == ST_STROBE) |-> (state_q == ST_STROBE) [*6] ##1 (state_q == ST_DONE))
      else $error("Strobe phase length wrong");
   ale_then_strobe_a: assert property (
      (state_q == ST_ADDR && mux_eff) |=> pin_out_o.p1[5] && pin_out_o.p1[6] ##1
      !pin_out_o.p1[5] ##1 (pin_out_o.p1[6] != pin_out_o.p1[7]))
      else $error("Address latch pulse not ahead of strobe");
   nonmux_seq_a: assert property (
      (state_q == ST_ADDR && !mux_eff) |=> (state_q == ST_STROBE))
      else $error("Separate-pin mode used latch phase");
   small_no_ext_a: assert property (
      (VARIANT == VAR_SMALL) |-> (state_q == ST_IDLE || state_q == ST_DONE))
      else $error("Smallest variant went off-chip");
endmodule : emipi_top

// *** tb/emipi_mem_model.sv ***
`timescale 1ns/1ps
// Off-chip byte-wide memory seen only through the resolved pin levels
module emipi_mem_model
   import emipi_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         mux_i,      // 1 = separate address pins
   input  wire emipi_ports_t lvl_i,      // Resolved pin levels
   output logic [7:0]        data_o,     // Read data for the data lines
   output logic              data_oe_o   // High while the model drives them
);
   logic [7:0]  mem_q [0:65535];  // Storage
   logic [7:0]  lo_q;             // Low address caught at the latch strobe
   logic [15:0] addr;             // Address decoded from the pins

   ////////////////////////////////////////////////////////////////////////
   // Address: separate pins, or high pins plus latched low byte
   assign addr = mux_i ? {lvl_i.p2, lvl_i.p3} : {lvl_i.p3, lo_q};
   // Drive the data lines only while the read strobe is low
   assign data_oe_o = ~lvl_i.p1[6];
   assign data_o    = mem_q[addr];

   ////////////////////////////////////////////////////////////////////////
   // Catch the low address and store written bytes
   always_ff @(posedge ref_clk_i) begin
      if (lvl_i.p1[5]) begin
         lo_q <= lvl_i.p4;
      end
      if (!lvl_i.p1[7]) begin
         mem_q[addr] <= lvl_i.p4;
      end
   end
endmodule : emipi_mem_model

// *** tb/external_memory_port_interface_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
// Self-checking bench for the external memory pin interface
module external_memory_port_interface_tb;
   import emipi_pkg::*;
   logic         ref_clk, rst, sfr_wr, xm_req, xm_done, xm_off, mem_oe, cfg_mux;
   logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata, xm_rdata, mem_d, rd;
   logic [7:0]   junk = 8'h5A;              // Floating data lines
   emipi_req_t   xm;
   emipi_ports_t latch, xbar, lvl, pin_out, pin_oe;
   logic         s_off;                     // Smallest variant routing flag
   emipi_ports_t s_out, s_oe;               // Smallest variant pins
   int           failures = 0;
   int           checked  = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock, floating pattern and pin resolution (strobe lines pulled high)
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always_ff @(posedge ref_clk) junk <= ~junk;
   always_comb begin   // Enabled pins drive both levels
      lvl.p1 = (pin_oe.p1 & pin_out.p1) | ~pin_oe.p1;
      lvl.p2 = (pin_oe.p2 & pin_out.p2) | ~pin_oe.p2;
      lvl.p3 = (pin_oe.p3 & pin_out.p3) | ~pin_oe.p3;
      lvl.p4 = (pin_oe.p4 & pin_out.p4) | (~pin_oe.p4 & (mem_oe ? mem_d : junk));
   end

   emipi_top #(.VARIANT(VAR_LARGE)) uut (.ref_clk_i(ref_clk), .rst_i(rst),
      .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata),
      .sfr_rdata_o(sfr_rdata), .xm_req_i(xm_req), .xm_i(xm), .xm_done_o(xm_done),
      .xm_offchip_o(xm_off), .xm_rdata_o(xm_rdata), .latch_i(latch), .xbar_oe_i(xbar),
      .pin_in_i(lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
   emipi_mem_model mem (.ref_clk_i(ref_clk), .mux_i(cfg_mux), .lvl_i(lvl),
      .data_o(mem_d), .data_oe_o(mem_oe));
   // Smallest variant on the same requests: must never leave the chip
   emipi_top #(.VARIANT(VAR_SMALL)) uut_small (.ref_clk_i(ref_clk), .rst_i(rst),
      .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata),
      .sfr_rdata_o(), .xm_req_i(xm_req), .xm_i(xm), .xm_done_o(),
      .xm_offchip_o(s_off), .xm_rdata_o(), .latch_i(latch), .xbar_oe_i(xbar),
      .pin_in_i(lvl), .pin_out_o(s_out), .pin_oe_o(s_oe));

   ////////////////////////////////////////////////////////////////////////
   // Register port and move helpers
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      sfr_addr = a;
      @(negedge ref_clk);
      `CHK(sfr_rdata, e)
   endtask : reg_rd
   // Mode field and mux bit, ALE width bits left at their reset value
   task automatic set_cfg(input logic m, input logic [1:0] md);
      cfg_mux = m;
      reg_wr(CFG_ADDR, {3'h0, m, md, 2'h3});
   endtask : set_cfg
   task automatic move(input logic w, input logic b8, input logic [15:0] a16,
                       input logic [7:0] lo, input logic [7:0] wd, input int ec,
                       input logic [15:0] ea, input logic eo);
      int   k;
      logic ale;
      ale = 1'b0;
      @(negedge ref_clk);
      xm_req = 1'b1;
      xm = '{wr: w, is8: b8, addr16: a16, low: lo, wdata: wd};
      for (k = 1; k <= 20; k++) begin
         @(negedge ref_clk);
         xm_req = 1'b0;
         // Smallest variant leaves every pin to latch and crossbar
         `CHK({s_oe, s_out}, {xbar, latch})
         // On-chip moves leave every pin to latch and crossbar
         if (!eo) begin
            `CHK(pin_oe, xbar)
            `CHK(pin_out, latch)
         end
         // Latch strobe carries the low address
         if (pin_oe.p1[5] && pin_out.p1[5]) begin
            ale = 1'b1;
            `CHK(pin_out.p4, ea[7:0])
         end
         // Data drivers off while reading
         if (pin_oe.p1[6] && !pin_out.p1[6]) `CHK(pin_oe.p4, 8'h00)
         // Strobe phase: address pins per pinout
         if (lvl.p1[6] == 1'b0 || lvl.p1[7] == 1'b0) begin
            `CHK(ale, !cfg_mux)
            if (cfg_mux) `CHK({lvl.p2, lvl.p3}, ea)
            else `CHK(lvl.p3, ea[15:8])
         end
         if (xm_done === 1'b1) break;
      end
      if (k > 20) begin
         failures++;
         end_of_test();
      end
      `CHK(k, ec)
      `CHK(xm_off, eo)
      `CHK(s_off, 1'b0)
      rd = xm_rdata;
      @(negedge ref_clk);
      `CHK(pin_oe, xbar)
      `CHK(pin_out, latch)
   endtask : move

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs;
      reg_rd(PAGE_SEL_ADDR, PAGE_SEL_RESET);
      reg_rd(CFG_ADDR, CFG_RESET);
      reg_rd(8'h55, 8'h00);
      reg_wr(8'h55, 8'h77);
      reg_wr(CFG_ADDR, 8'hFF);
      reg_rd(CFG_ADDR, 8'h1F);
      reg_wr(PAGE_SEL_ADDR, 8'hA5);
      reg_rd(PAGE_SEL_ADDR, 8'hA5);
   endtask : t_regs
   // Multiplexed off-chip move: address, hold, six strobe cycles, release, done
   task automatic t_mux;
      set_cfg(1'b0, MODE_ONCHIP);
      move(1'b1, 1'b0, 16'h3456, 8'h00, 8'h11, 2, 16'h3456, 1'b0);
      set_cfg(1'b0, MODE_OFFCHIP);
      move(1'b1, 1'b0, 16'h1234, 8'h00, 8'hAB, 10, 16'h1234, 1'b1);
      move(1'b0, 1'b0, 16'h1234, 8'h00, 8'h00, 10, 16'h1234, 1'b1);
      `CHK(rd, 8'hAB)
      reg_wr(PAGE_SEL_ADDR, 8'hFF);
      move(1'b1, 1'b1, 16'h0000, 8'hFF, 8'hC3, 10, 16'hFFFF, 1'b1);
      move(1'b0, 1'b0, 16'hFFFF, 8'h00, 8'h00, 10, 16'hFFFF, 1'b1);
      `CHK(rd, 8'hC3)
   endtask : t_mux
   // Separate pins skip the hold phase: one cycle shorter
   task automatic t_nonmux;
      set_cfg(1'b1, MODE_OFFCHIP);
      move(1'b1, 1'b0, 16'h4321, 8'h00, 8'h5E, 9, 16'h4321, 1'b1);
      move(1'b0, 1'b0, 16'h4321, 8'h00, 8'h00, 9, 16'h4321, 1'b1);
      `CHK(rd, 8'h5E)
   endtask : t_nonmux
   task automatic t_split;
      set_cfg(1'b0, MODE_SPLIT_PG);
      move(1'b1, 1'b0, 16'h1FFF, 8'h00, 8'h22, 2, 16'h1FFF, 1'b0);
      move(1'b1, 1'b0, 16'h2000, 8'h00, 8'h66, 10, 16'h2000, 1'b1);
      reg_wr(PAGE_SEL_ADDR, 8'h00);
      move(1'b1, 1'b1, 16'hFFFF, 8'h40, 8'h33, 2, 16'h0040, 1'b0);
      set_cfg(1'b0, MODE_SPLIT_LAT);
      move(1'b1, 1'b1, 16'h0000, 8'h77, 8'h9D, 10, 16'hFF77, 1'b1);
      set_cfg(1'b0, MODE_OFFCHIP);
      move(1'b0, 1'b0, 16'hFF77, 8'h00, 8'h00, 10, 16'hFF77, 1'b1);
      `CHK(rd, 8'h9D)
   endtask : t_split

   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: latches parked high, strobe pins skipped by the crossbar
   initial begin
      rst = 1'b1; sfr_wr = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
      xm_req = 1'b0; xm = '0; cfg_mux = 1'b0;
      latch = '{p4: 8'hFF, p3: 8'hFF, p2: 8'hFF, p1: 8'hFF};
      xbar = '{p4: 8'hFF, p3: 8'hF0, p2: 8'h00, p1: 8'h1F};
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      t_regs();
      t_mux();
      t_nonmux();
      t_split();
      end_of_test();
   end
endmodule : external_memory_port_interface_tb
